// ==== osm_pkg.sv ====
// Constants and types shared by the oscillator mode select block
package osm_pkg;

    // Oscillator mode codes held in the non-volatile configuration field
    localparam logic [3:0] MODE_LOW_POWER_CRYSTAL = 4'h0;
    localparam logic [3:0] MODE_STANDARD_CRYSTAL = 4'h1;
    localparam logic [3:0] MODE_FAST_CRYSTAL = 4'h2;
    localparam logic [3:0] MODE_RESISTOR_CAPACITOR = 4'h3;
    localparam logic [3:0] MODE_EXTERNAL_CLOCK = 4'h4;
    localparam logic [3:0] MODE_EXTERNAL_CLOCK_IO = 4'h5;
    localparam logic [3:0] MODE_FAST_CRYSTAL_MULTIPLIED = 4'h6;
    localparam logic [3:0] MODE_RESISTOR_CAPACITOR_IO = 4'h7;
    localparam logic [3:0] MODE_INTERNAL_OSC_ALL_IO = 4'h8;
    localparam logic [3:0] MODE_INTERNAL_OSC_CLKOUT = 4'h9;
    localparam logic [3:0] MODE_RESET_VALUE = 4'h3;

    // Internal frequency select codes
    localparam logic [2:0] FREQ_8MHZ = 3'h7;
    localparam logic [2:0] FREQ_4MHZ = 3'h6;
    localparam logic [2:0] FREQ_LOWEST = 3'h0;
    localparam logic [2:0] FREQ_RESET_VALUE = 3'h6;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFS_OSC_CONTROL = 8'h00;
    localparam logic [7:0] OFS_OSC_TUNE = 8'h04;
    localparam logic [7:0] OFS_OSC_STATUS = 8'h08;

    // Field positions in the control and tuning registers
    localparam int FREQ_SEL_LSB = 4;
    localparam int FREQ_SEL_MSB = 6;
    localparam int LOW_FREQ_SRC_BIT = 7;
    localparam int MULT_EN_BIT = 6;
    localparam int TUNE_MSB = 4;
    localparam logic [4:0] TUNE_RESET_VALUE = 5'h00;

    // Field positions in the status register
    localparam int ST_MODE_LSB = 0;
    localparam int ST_MODE_MSB = 3;
    localparam int ST_PLL_BIT = 4;
    localparam int ST_FAST_EN_BIT = 5;
    localparam int ST_SLOW_EN_BIT = 6;
    localparam int ST_READY_BIT = 7;
    localparam int ST_OUT_GPIO_BIT = 8;
    localparam int ST_IN_GPIO_BIT = 9;

    // Oscillator start-up count, in source clock ticks, for the crystal and RC modes
    localparam logic [10:0] OST_TICKS = 11'h400;

    // Postscaler width: the deepest divide is 256
    localparam int POST_W = 8;

    // Start-up sequencer states, Gray coded along reset -> wait -> run -> sleep
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN = 2'b11,
        ST_SLEEP = 2'b10
    } osm_state_t;

endpackage

// ==== osm_top.sv ====
// Oscillator mode select, pin routing, internal oscillator and multiplier control
`timescale 1ns/1ps
// Overview of operation
// - Ten modes from sampled configuration field
// - Crystal modes drive resonator across both pins
// - Fast crystal mode accepts external clock input
// - Crystal multiplier only in multiplied crystal mode
// - Multiplied crystal mode sets pll_active; source ticks pass unmultiplied
// - Enable bit unavailable in multiplied crystal mode
// - External clock modes skip start-up delay
// - External clock mode drives Fosc/4 out
// - External clock io mode: out pin GPIO
// - RC mode drives Fosc/4 on out pin
// - RC io mode: out pin is GPIO
// - Internal oscillator multiplier under software control
// - Fast oscillator direct or postscaled 31k-4M
// - Fast oscillator enabled for 125k-8M selection
// - Slow oscillator runs when selected or needed
// - Frequency select field picks internal source
// - Clkout mode: out Fosc/4, in GPIO
// - All-io mode: both pins GPIO
// - Internal multiplier only at 4 or 8 MHz
// - Enable bit forced and read zero elsewhere
// - Lowest setting picks divided fast or slow
module osm_top
    import osm_pkg::*;
(
    // Clock, reset and clock enable
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Non-volatile mode field and system requests
    input wire logic [3:0] mode_cfg,
    input wire logic sleep_req,
    input wire logic pwrt_en,
    input wire logic fscm_en,
    input wire logic wdt_en,
    input wire logic two_speed_en,
    // Internal oscillator ticks, one cycle each
    input wire logic fast_osc_tick,
    input wire logic slow_osc_tick,
    // Oscillator input pin
    input wire logic osc_in_pin_i,
    output logic osc_in_pin_o,
    output logic osc_in_pin_oe,
    // Oscillator output pin
    input wire logic osc_out_pin_i,
    output logic osc_out_pin_o,
    output logic osc_out_pin_oe,
    // Port A bits 6 and 7 from and to the port logic
    input wire logic port_a_bit6_o,
    input wire logic port_a_bit6_oe,
    input wire logic port_a_bit7_o,
    input wire logic port_a_bit7_oe,
    output logic port_a_bit6_i,
    output logic port_a_bit7_i,
    // Clock generator state
    output logic fast_osc_en,
    output logic slow_osc_en,
    output logic pll_active,
    output logic clk_tick,
    output logic clk_ready
);

    // Mode decoding, used for the captured mode and for the raw field at start-up
    function automatic logic is_crystal(input logic [3:0] m);
        is_crystal = (m == MODE_LOW_POWER_CRYSTAL) || (m == MODE_STANDARD_CRYSTAL)
            || (m == MODE_FAST_CRYSTAL) || (m == MODE_FAST_CRYSTAL_MULTIPLIED);
    endfunction

    function automatic logic is_internal(input logic [3:0] m);
        is_internal = (m == MODE_INTERNAL_OSC_ALL_IO) || (m == MODE_INTERNAL_OSC_CLKOUT);
    endfunction

    function automatic logic is_ext_clock(input logic [3:0] m);
        is_ext_clock = (m == MODE_EXTERNAL_CLOCK) || (m == MODE_EXTERNAL_CLOCK_IO);
    endfunction

    // Captured mode and start-up state
    logic [3:0] mode_reg; // Held configuration, fixed after capture
    osm_state_t state_reg; // Start-up sequencer
    osm_state_t state_next;
    logic [10:0] ost_reg; // Start-up tick counter
    logic [10:0] ost_next;

    // Software registers
    logic [2:0] freq_sel_reg; // Internal frequency select
    logic low_src_reg; // Lowest-setting source select
    logic mult_en_reg; // Multiplier enable for internal modes
    logic [4:0] tune_reg; // Tuning value, stored and read back only

    // Clock path state
    logic osc_in_d_reg; // Previous sample of input pin for edge detect
    logic [POST_W-1:0] post_reg; // Postscaler counter
    logic [1:0] div4_reg; // Fosc/4 divider
    logic clk_tick_reg;
    logic osc_out_reg;

    // Mode classes
    wire logic mode_xtal = is_crystal(mode_reg);
    wire logic mode_int = is_internal(mode_reg);
    wire logic mode_ext = is_ext_clock(mode_reg);
    wire logic mode_xpll = (mode_reg == MODE_FAST_CRYSTAL_MULTIPLIED);
    // Output pin carries Fosc/4
    wire logic out_clkout = (mode_reg == MODE_EXTERNAL_CLOCK)
        || (mode_reg == MODE_RESISTOR_CAPACITOR)
        || (mode_reg == MODE_INTERNAL_OSC_CLKOUT);
    // Output pin handed to port A bit 6
    wire logic out_gpio = (mode_reg == MODE_EXTERNAL_CLOCK_IO)
        || (mode_reg == MODE_RESISTOR_CAPACITOR_IO)
        || (mode_reg == MODE_INTERNAL_OSC_ALL_IO);
    // Input pin handed to port A bit 7 in both internal modes
    wire logic in_gpio = mode_int;
    wire logic captured = (state_reg != ST_RESET);

    // APB decode; zero-wait slave, stalled only by the clock enable
    wire logic hit_ctrl = (paddr == OFS_OSC_CONTROL);
    wire logic hit_tune = (paddr == OFS_OSC_TUNE);
    wire logic hit_stat = (paddr == OFS_OSC_STATUS);
    wire logic hit_any = hit_ctrl || hit_tune || hit_stat;
    wire logic access = psel && penable && clk_en;
    wire logic wr_ctrl = access && pwrite && hit_ctrl;
    wire logic wr_tune = access && pwrite && hit_tune;
    assign pready = clk_en;
    assign pslverr = psel && penable && !hit_any;

    // Multiplier bit only exists in internal modes; elsewhere it is forced low
    wire logic mult_avail = mode_int;
    wire logic mult_bit = mult_avail && mult_en_reg;

    // Internal frequency selection
    wire logic freq_top = (freq_sel_reg == FREQ_8MHZ);
    wire logic freq_low = (freq_sel_reg == FREQ_LOWEST);
    wire logic use_slow = freq_low && !low_src_reg;
    wire logic pll_freq_ok = (freq_sel_reg == FREQ_8MHZ) || (freq_sel_reg == FREQ_4MHZ);

    // Crystal multiplier by mode alone; internal one needs bit, mode and frequency
    wire logic pll_xtal = mode_xpll;
    wire logic pll_int = mode_int && mult_bit && pll_freq_ok;
    assign pll_active = captured && (pll_xtal || pll_int);

    // Fast oscillator runs for 125 kHz..8 MHz and for the divided lowest setting
    wire logic fast_need = mode_int && (!freq_low || low_src_reg);
    // Slow oscillator runs when it is the clock or a system feature needs it
    wire logic slow_need = (mode_int && use_slow)
        || pwrt_en || fscm_en || wdt_en || two_speed_en;
    assign fast_osc_en = captured && fast_need;
    assign slow_osc_en = slow_need;

    // Postscaler mask: divide by 2^(7-sel) below 8 MHz, by 256 at the lowest setting
    function automatic logic [POST_W-1:0] post_mask(input logic [2:0] sel);
        logic [POST_W-1:0] m;
        m = '1;
        if (sel != FREQ_LOWEST)
            m = POST_W'((1 << (FREQ_8MHZ - sel)) - 1);
        post_mask = m;
    endfunction

    wire logic [POST_W-1:0] pmask = post_mask(freq_sel_reg);
    wire logic post_wrap = fast_osc_tick && ((post_reg & pmask) == pmask);
    // Internal source tick: fast direct, postscaled, or slow direct
    wire logic int_tick = freq_top ? fast_osc_tick
        : (use_slow ? slow_osc_tick : post_wrap);

    // External source tick: rising edge on the input pin, including a driven clock
    wire logic ext_tick = osc_in_pin_i && !osc_in_d_reg;
    wire logic src_tick = mode_int ? int_tick : ext_tick;

    // Start-up delay applies to all but the external clock and internal oscillator modes
    wire logic need_ost = !is_ext_clock(mode_cfg) && !is_internal(mode_cfg);
    wire logic ost_done = (ost_reg == OST_TICKS);

    // Sequencer next state
    always_comb
    begin
        state_next = state_reg;
        ost_next = ost_reg;
        unique case (state_reg)
            // Capture the mode field once, on the first enabled edge after reset
            ST_RESET:
            begin
                ost_next = '0;
                state_next = need_ost ? ST_WAIT : ST_RUN;
            end
            // Count source ticks until the oscillator has settled
            ST_WAIT:
            begin
                if (ost_done)
                    state_next = ST_RUN;
                else if (src_tick)
                    ost_next = ost_reg + 11'h001;
            end
            // Running; a sleep request stops the clock
            ST_RUN:
            begin
                if (sleep_req)
                    state_next = ST_SLEEP;
            end
            // Wake: external clock modes resume at once
            ST_SLEEP:
            begin
                if (!sleep_req)
                begin
                    ost_next = '0;
                    state_next = (mode_ext || mode_int) ? ST_RUN : ST_WAIT;
                end
            end
        endcase
    end

    // Sequencer and mode capture; the mode field is taken only once
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= ST_RESET;
            ost_reg <= '0;
            mode_reg <= MODE_RESET_VALUE;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            ost_reg <= ost_next;
            if (state_reg == ST_RESET)
                mode_reg <= mode_cfg;
        end
    end

    // Software registers; the multiplier bit is ignored where unavailable
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            freq_sel_reg <= FREQ_RESET_VALUE;
            low_src_reg <= 1'b0;
            mult_en_reg <= 1'b0;
            tune_reg <= TUNE_RESET_VALUE;
        end
        else if (clk_en)
        begin
            if (wr_ctrl)
                freq_sel_reg <= pwdata[FREQ_SEL_MSB:FREQ_SEL_LSB];
            if (wr_tune)
            begin
                low_src_reg <= pwdata[LOW_FREQ_SRC_BIT];
                mult_en_reg <= pwdata[MULT_EN_BIT] && mult_avail;
                tune_reg <= pwdata[TUNE_MSB:0];
            end
        end
    end

    // Read data, registered for the access phase
    wire logic [31:0] rd_ctrl = {24'h000000, 1'b0, freq_sel_reg, 4'h0};
    wire logic [31:0] rd_tune = {24'h000000, low_src_reg, mult_bit, 1'b0, tune_reg};
    wire logic [31:0] rd_stat = {22'h0, in_gpio, out_gpio, clk_ready, slow_osc_en,
        fast_osc_en, pll_active, mode_reg};
    wire logic [31:0] rd_mux = hit_ctrl ? rd_ctrl
        : (hit_tune ? rd_tune : (hit_stat ? rd_stat : 32'h00000000));

    // Read data is loaded in the setup cycle so it stands through the access phase
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            prdata <= 32'h00000000;
        else if (clk_en && psel && !penable)
            prdata <= pwrite ? 32'h00000000 : rd_mux;
    end

    // Clock path: edge detect, postscaler, Fosc/4 divider, device tick
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            osc_in_d_reg <= 1'b0;
            post_reg <= '0;
            div4_reg <= 2'h0;
            clk_tick_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            osc_in_d_reg <= osc_in_pin_i;
            if (fast_osc_tick)
                post_reg <= post_reg + POST_W'(1);
            // The device clock only ticks once the sequencer is running
            clk_tick_reg <= (state_reg == ST_RUN) && src_tick;
            if ((state_reg == ST_RUN) && src_tick)
                div4_reg <= div4_reg + 2'h1;
        end
    end

    assign clk_tick = clk_tick_reg;
    assign clk_ready = (state_reg == ST_RUN);

    // Output pin data: inverting drive across a resonator, Fosc/4, or port bit 6
    wire logic out_next = mode_xtal ? !osc_in_pin_i
        : (out_clkout ? div4_reg[1] : port_a_bit6_o);
    // The resonator amplifier is off in sleep so the crystal stops
    wire logic out_drive = captured
        && ((mode_xtal && state_reg != ST_SLEEP) || out_clkout
        || (out_gpio && port_a_bit6_oe));

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            osc_out_reg <= 1'b0;
        else if (clk_en)
            osc_out_reg <= out_next;
    end

    // Pin drivers; the input pin is only ever driven as port bit 7
    assign osc_out_pin_o = osc_out_reg;
    assign osc_out_pin_oe = out_drive;
    assign osc_in_pin_o = port_a_bit7_o;
    assign osc_in_pin_oe = captured && in_gpio && port_a_bit7_oe;
    // Port reads see the pin levels; meaningless unless the pin is a GPIO
    assign port_a_bit6_i = osc_out_pin_i;
    assign port_a_bit7_i = osc_in_pin_i;

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    // Mode stays fixed once captured
    mode_held_a: assert property (captured && clk_en |=> $stable(mode_reg))
        else $error("mode changed after capture");

    // Crystal multiplier follows the mode alone
    xtal_pll_a: assert property (captured && mode_xpll |-> pll_active)
        else $error("crystal multiplier not active");

    // Multiplier off outside its modes and frequencies
    pll_gate_a: assert property (pll_active |-> mode_xpll
        || (mode_int && mult_en_reg && pll_freq_ok))
        else $error("multiplier active without cause");

    // Enable bit reads zero where unavailable
    mult_zero_a: assert property (captured && !mode_int |-> !mult_bit && !rd_tune[MULT_EN_BIT])
        else $error("multiplier bit not forced low");

    // External clock modes are running at the first edge after capture
    ext_run_a: assert property ($rose(captured) && mode_ext |-> clk_ready)
        else $error("start-up delay in external clock mode");

    // Fast oscillator only in the documented range
    fast_en_a: assert property (fast_osc_en |-> mode_int && (!freq_low || low_src_reg))
        else $error("fast oscillator enabled wrongly");

    // Slow oscillator follows the watchdog and power-up timer requests
    slow_en_a: assert property (wdt_en || pwrt_en |-> slow_osc_en)
        else $error("slow oscillator not enabled");

    // Fosc/4 appears on the output pin one cycle after the divider
    clkout_pin_a: assert property (captured && out_clkout && clk_en
        |=> osc_out_pin_o == $past(div4_reg[1]) && osc_out_pin_oe)
        else $error("clock output missing");

    // Input pin drives only as port bit 7 in internal modes
    in_pin_a: assert property (osc_in_pin_oe |-> mode_int && port_a_bit7_oe)
        else $error("input pin driven outside internal modes");

    // Main scenarios
    cov_xpll_c: cover property (captured && mode_xpll && clk_tick);
    cov_int_pll_c: cover property (pll_int && captured ##1 clk_tick);
    cov_wake_c: cover property (state_reg == ST_SLEEP ##1 state_reg == ST_WAIT);
    cov_low_c: cover property (fast_osc_en && freq_low && low_src_reg);

endmodule

// ==== osm_ext_clock.sv ====
// External clock source that stands at the oscillator input pin
`timescale 1ns/1ps
module osm_ext_clock
(
    // Bench clock
    input wire logic mclk,
    // Run and speed control
    input wire logic run,
    input wire logic slow,
    // Source clock towards the pin
    output logic src_clk
);
    // Divider of the bench clock
    logic [2:0] div_reg;

    // Stands low outside run, so no stray edge reaches the start-up counter
    always_ff @(posedge mclk)
    begin
        if (run)
            div_reg <= div_reg + 3'h1;
        else
            div_reg <= 3'h0;
    end

    // Prompt source is four cycles a period, slow one eight
    assign src_clk = slow ? div_reg[2] : div_reg[1];
endmodule

// ==== oscillator_mode_select_and_pll_bench.sv ====
// Self-checking bench for the oscillator mode select block
`timescale 1ns/1ps
module oscillator_mode_select_and_pll_bench;
    import osm_pkg::*;
    logic mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, sleep_req = 0, run = 0;
    logic [7:0] paddr = 8'h00;
    logic b6_oe = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0] mode_cfg = 4'h4, feat = 4'h0, cnt = 4'h0;
    logic fast_osc_tick = 0, slow_osc_tick = 0, src_clk, rerr, pready, pslverr;
    logic osc_in_pin_o, osc_in_pin_oe, osc_out_pin_o, osc_out_pin_oe, port_a_bit6_i;
    logic port_a_bit7_i, fast_osc_en, slow_osc_en, pll_active, clk_tick, clk_ready;
    int num_errors = 0, checks_done = 0, tcount, rcount, m, i;
    // Bench clock at 200 MHz
    always #2.5 mclk = ~mclk;
    // Internal oscillator ticks: fast every 4 cycles, slow every 16
    always @(posedge mclk)
    begin
        cnt <= cnt + 4'h1;
        fast_osc_tick <= (cnt[1:0] == 2'h3);
        slow_osc_tick <= (cnt == 4'hF);
    end
    // Released output pin shows a changing pattern, never a held value
    wire osc_in_w = osc_in_pin_oe ? osc_in_pin_o : src_clk;
    wire osc_out_w = osc_out_pin_oe ? osc_out_pin_o : cnt[0];
    osm_ext_clock src (.mclk(mclk), .run(run), .slow(1'b0), .src_clk(src_clk));
    osm_top dut (.mclk(mclk), .arst_n(arst_n), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mode_cfg(mode_cfg), .sleep_req(sleep_req), .pwrt_en(feat[3]),
        .fscm_en(feat[2]), .wdt_en(feat[1]), .two_speed_en(feat[0]),
        .fast_osc_tick(fast_osc_tick), .slow_osc_tick(slow_osc_tick), .osc_in_pin_i(osc_in_w),
        .osc_in_pin_o(osc_in_pin_o), .osc_in_pin_oe(osc_in_pin_oe), .osc_out_pin_i(osc_out_w),
        .osc_out_pin_o(osc_out_pin_o), .osc_out_pin_oe(osc_out_pin_oe),
        .port_a_bit6_o(cnt[1]), .port_a_bit6_oe(b6_oe), .port_a_bit7_o(cnt[2]),
        .port_a_bit7_oe(1'b1), .port_a_bit6_i(port_a_bit6_i), .port_a_bit7_i(port_a_bit7_i),
        .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en), .pll_active(pll_active),
        .clk_tick(clk_tick), .clk_ready(clk_ready));
    // Prints the counts and the verdict, then stops
    task automatic final_report;
        $display("checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Compares seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Counts that may slip by one at the window edges
    task automatic near(input int a, input int b);
        chk({31'h0, (a - b) <= 1 && (b - a) <= 1 && b > 0}, 32'h1);
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    // Reset with a new mode field; capture happens at the edge after release
    task automatic rst_mode(input logic [3:0] md);
        arst_n <= 1'b0;
        mode_cfg <= md;
        feat <= 4'h0;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
    endtask
    // Bounded wait for the run state
    task automatic wait_ready;
        for (i = 0; i < 6000 && clk_ready !== 1'b1; i++)
            @(posedge mclk);
        chk(clk_ready, 1'b1);
    endtask
    // Counts clock ticks and rises of the output pin over 400 cycles
    task automatic measure;
        logic prev;
        tcount = 0;
        rcount = 0;
        prev = osc_out_pin_o;
        repeat (400)
        begin
            @(posedge mclk);
            tcount += (clk_tick === 1'b1);
            rcount += (osc_out_pin_o === 1'b1 && prev === 1'b0);
            prev = osc_out_pin_o;
        end
    endtask
    // Status fields: in gpio, out gpio, ready, multiplier, mode
    function automatic logic [31:0] exp_st(input logic [3:0] md);
        exp_st = {22'h0, md >= 4'h8, md inside {4'h5, 4'h7, 4'h8}, 1'b1, 2'b00, md == 4'h6, md};
    endfunction
    // Hang guard, sized well above the longest expected run
    initial
    begin
        #400000;
        num_errors++;
        final_report();
    end
    initial
    begin
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        run <= 1'b1;
        @(posedge mclk);
        apb(1'b0, OFS_OSC_CONTROL, 32'h0);
        chk(rdat & 32'h70, 32'h60);
        apb(1'b0, 8'h0C, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdat, 32'h0);
        // Every mode: start-up, status and pin routing
        for (m = 0; m < 10; m++)
        begin
            rst_mode(m[3:0]);
            repeat (2) @(posedge mclk);
            chk(clk_ready, m inside {4, 5, 8, 9});
            wait_ready();
            apb(1'b0, OFS_OSC_STATUS, 32'h0);
            chk(rdat & 32'h39F, exp_st(m[3:0]));
            chk(osc_out_pin_oe, !(m inside {5, 7, 8}));
            chk(osc_in_pin_oe, m >= 8);
            chk(port_a_bit6_i, osc_out_w);
            if (m inside {5, 7, 8})
            begin
                b6_oe <= 1'b1;
                @(posedge mclk);
                chk(osc_out_pin_oe, 1'b1);
                b6_oe <= 1'b0;
                @(posedge mclk);
            end
            if (m inside {2, 3, 4, 9})
            begin
                measure();
                if (m == 2)
                begin
                    near(rcount, tcount);
                    near(tcount, 100);
                end
                else
                    near(rcount, tcount / 4);
            end
        end
        // Internal source: direct and postscaled fast oscillator
        rst_mode(4'h8);
        wait_ready();
        for (m = 7; m >= 4; m--)
        begin
            apb(1'b1, OFS_OSC_CONTROL, m << 4);
            measure();
            near(tcount, 100 >> (7 - m));
            chk(fast_osc_en, 1'b1);
        end
        apb(1'b1, OFS_OSC_CONTROL, 32'h0);
        measure();
        near(tcount, 25);
        chk({fast_osc_en, slow_osc_en}, 2'b01);
        apb(1'b1, OFS_OSC_TUNE, 32'h80);
        chk(fast_osc_en, 1'b1);
        // Multiplier with the internal oscillator, at frequency selects 4 to 7
        apb(1'b1, OFS_OSC_TUNE, 32'h40);
        apb(1'b0, OFS_OSC_TUNE, 32'h0);
        chk(rdat, 32'h40);
        for (m = 4; m < 8; m++)
        begin
            apb(1'b1, OFS_OSC_CONTROL, m << 4);
            chk(pll_active, m >= 6);
        end
        // Slow oscillator follows each feature enable
        apb(1'b1, OFS_OSC_TUNE, 32'h0);
        chk(slow_osc_en, 1'b0);
        for (m = 0; m < 4; m++)
        begin
            feat <= 4'h1 << m;
            @(posedge mclk);
            @(posedge mclk);
            chk(slow_osc_en, 1'b1);
        end
        // Multiplied crystal mode ignores the enable bit
        rst_mode(4'h6);
        wait_ready();
        apb(1'b1, OFS_OSC_TUNE, 32'h40);
        apb(1'b0, OFS_OSC_TUNE, 32'h0);
        chk(rdat, 32'h0);
        chk(pll_active, 1'b1);
        // External clock: enable bit forced low, tune bits kept
        rst_mode(4'h4);
        wait_ready();
        apb(1'b1, OFS_OSC_TUNE, 32'hFF);
        apb(1'b0, OFS_OSC_TUNE, 32'h0);
        chk(rdat, 32'h9F);
        chk(pll_active, 1'b0);
        mode_cfg <= 4'h8;
        apb(1'b0, OFS_OSC_STATUS, 32'h0);
        chk(rdat & 32'hF, 32'h4);
        // Sleep and wake with no start-up delay
        sleep_req <= 1'b1;
        repeat (8) @(posedge mclk);
        measure();
        chk(tcount, 32'h0);
        sleep_req <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(clk_ready, 1'b1);
        final_report();
    end
endmodule
